// ---- hw/edxs_top.sv ----
// Purpose: Sequences external data moves with programmable stretch and wait
// Assumes: Core raises EXT_DATA_MOVE_REQ for one clock when it decodes the move
// Notes:   Move starts at the next machine cycle boundary
// Behaviour
// - Fetch cycle of four clocks, then access
// - Three stretch bits give eight durations
// - Stretch 0..7 gives 2..9 machine cycles
// - Only the data move is lengthened
// - Stretch resets to one, zero allowed
// - Strobe lasts 2, then 4 per step
// - Wait enable turns aux pin into wait
// - Stretch still sets the minimum length
// - Wait sampled in state three before strobe end
// - Asserted wait inserts one machine cycle
// - Unlimited waits, ends once wait released
// - Wait enable written only after unlock
// - Machine cycle is four states in order
// - Pointer address from selected data pointer
// - Select bit picks pointer, others read zero
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module edxs_top (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    // Register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output var  logic [7:0]  REG_RDATA,
    // Core side
    input  wire logic        EXT_DATA_MOVE_REQ,
    input  wire logic        EXT_DATA_MOVE_WRITE,
    input  wire logic        EXT_DATA_MOVE_USE_PTR,
    input  wire logic [7:0]  EXT_DATA_MOVE_RI_ADDR,
    input  wire logic [7:0]  EXT_DATA_MOVE_PAGE_ADDR,
    input  wire logic [7:0]  EXT_DATA_MOVE_WDATA,
    output var  logic [7:0]  EXT_DATA_MOVE_RDATA,
    output var  logic        EXT_DATA_MOVE_DONE,
    output logic             EXT_DATA_MOVE_BUSY,
    output logic             CPU_HOLD,
    output var  logic [1:0]  MACHINE_STATE,
    // Aux port bit zero
    input  wire logic        AUX_PORT_LATCH,
    output logic             AUX_PORT_LEVEL,
    input  wire logic        AUX0_I,
    output logic             AUX0_O,
    output logic             AUX0_OE,
    // External data bus
    output var  logic [15:0] EXT_ADDR,
    input  wire logic [7:0]  EXT_DATA_I,
    output var  logic [7:0]  EXT_DATA_O,
    output var  logic        EXT_DATA_OE,
    output logic             EXT_RD_N,
    output logic             EXT_WR_N
);
    import edxs_pkg::*;

    edxs_phase_t phase_ff;
    edxs_seq_t   seq_ff;
    edxs_ta_t    ta_ff;
    logic [2:0]  stretch_ff;
    logic        wait_enable_ff;
    logic        pointer_sel_ff;
    logic [15:0] primary_ff;
    logic [15:0] secondary_ff;
    logic [3:0]  ta_cnt_ff;
    logic        req_pend_ff;
    logic        write_ff;
    logic        short_ff;
    logic        first_ff;
    logic [3:0]  rem_ff;
    logic        ext_ff;
    logic        strobe_ff;
    logic        aux_level;
    logic        wait_hit;
    logic        access_end;
    logic        wr_clock_ctrl;
    logic        wr_memory_map;
    logic        wr_timed;
    logic [15:0] sel_pointer;

    assign wr_clock_ctrl = REG_WR && (REG_ADDR == OFS_CLOCK_CTRL);
    assign wr_memory_map = REG_WR && (REG_ADDR == OFS_MEMORY_MAP);
    assign wr_timed      = REG_WR && (REG_ADDR == OFS_TIMED_ACCESS);
    assign sel_pointer   = pointer_sel_ff ? secondary_ff : primary_ff;

    // Four states per machine cycle, free running
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            phase_ff <= PH_ONE;
        end else begin
            unique case (phase_ff)
                PH_ONE:   phase_ff <= PH_TWO;
                PH_TWO:   phase_ff <= PH_THREE;
                PH_THREE: phase_ff <= PH_FOUR;
                PH_FOUR:  phase_ff <= PH_ONE;
            endcase
        end
    end
    assign MACHINE_STATE = phase_ff;

    // Stretch select, reset to one
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            stretch_ff <= STRETCH_RESET;
        end else if (wr_clock_ctrl) begin
            stretch_ff <= REG_WDATA[STRETCH_MSB:STRETCH_LSB];
        end
    end

    // Unlock sequence: first key, second key, then a short open window
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ta_ff     <= TA_LOCKED;
            ta_cnt_ff <= 4'h0;
        end else if (wr_timed && REG_WDATA == TA_KEY_FIRST) begin
            ta_ff     <= TA_ARMED;
            ta_cnt_ff <= TA_WINDOW_CLOCKS;
        end else if (wr_timed && ta_ff == TA_ARMED && REG_WDATA == TA_KEY_SECOND) begin
            ta_ff     <= TA_OPEN;
            ta_cnt_ff <= TA_WINDOW_CLOCKS;
        end else if (wr_timed || wr_memory_map || ta_cnt_ff == 4'h1) begin
            ta_ff     <= TA_LOCKED;
            ta_cnt_ff <= 4'h0;
        end else if (ta_cnt_ff != 4'h0) begin
            ta_cnt_ff <= ta_cnt_ff - 4'h1;
        end
    end

    // Wait enable only changes inside the open window
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            wait_enable_ff <= WAIT_ENABLE_RESET;
        end else if (wr_memory_map && ta_ff == TA_OPEN) begin
            wait_enable_ff <= REG_WDATA[WAIT_ENABLE_BIT];
        end
    end

    chk_wait_lock: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (ta_ff != TA_OPEN) |=> $stable(wait_enable_ff))
        else $error("wait enable changed without unlock");

    // Data pointers and pointer select
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            pointer_sel_ff <= POINTER_SEL_RESET;
            primary_ff     <= {POINTER_RESET, POINTER_RESET};
            secondary_ff   <= {POINTER_RESET, POINTER_RESET};
        end else if (REG_WR) begin
            unique case (REG_ADDR)
                OFS_POINTER_SEL:  pointer_sel_ff     <= REG_WDATA[POINTER_SEL_BIT];
                OFS_PRIMARY_LO:   primary_ff[7:0]    <= REG_WDATA;
                OFS_PRIMARY_HI:   primary_ff[15:8]   <= REG_WDATA;
                OFS_SECONDARY_LO: secondary_ff[7:0]  <= REG_WDATA;
                OFS_SECONDARY_HI: secondary_ff[15:8] <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                OFS_CLOCK_CTRL:   REG_RDATA <= {5'h00, stretch_ff};
                OFS_MEMORY_MAP:   REG_RDATA <= {wait_enable_ff, 7'h00};
                OFS_POINTER_SEL:  REG_RDATA <= {7'h00, pointer_sel_ff};
                OFS_PRIMARY_LO:   REG_RDATA <= primary_ff[7:0];
                OFS_PRIMARY_HI:   REG_RDATA <= primary_ff[15:8];
                OFS_SECONDARY_LO: REG_RDATA <= secondary_ff[7:0];
                OFS_SECONDARY_HI: REG_RDATA <= secondary_ff[15:8];
                default:          REG_RDATA <= 8'h00;
            endcase
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    // Aux pin: port bit when wait is off, wait input when on
    edxs_pin_sync u_aux_sync (
        .SYS_CLK (SYS_CLK),
        .RESET   (RESET),
        .PIN_IN  (AUX0_I),
        .LEVEL   (aux_level)
    );
    assign AUX0_O         = 1'b0;
    assign AUX0_OE        = !wait_enable_ff && !AUX_PORT_LATCH;
    assign AUX_PORT_LEVEL = aux_level;

    // Wait sampled in state three; long form one cycle ahead of the last
    assign wait_hit = (seq_ff == SQ_ACCESS) && (phase_ff == PH_THREE) && wait_enable_ff
                      && !aux_level && (short_ff ? (rem_ff == 4'h1) : (rem_ff == 4'h2));

    // Request held until the next machine cycle boundary
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            req_pend_ff <= 1'b0;
        end else if (seq_ff == SQ_IDLE && phase_ff == PH_FOUR) begin
            // Taken here by the sequencer, so nothing may stay pending
            req_pend_ff <= 1'b0;
        end else if (EXT_DATA_MOVE_REQ) begin
            req_pend_ff <= 1'b1;
        end
    end

    assign access_end = (seq_ff == SQ_ACCESS) && (phase_ff == PH_FOUR) && (rem_ff == 4'h1)
                        && !ext_ff;

    // Move sequencer: fetch cycle, then 1 + stretch access cycles plus waits
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            seq_ff   <= SQ_IDLE;
            rem_ff   <= 4'h0;
            short_ff <= 1'b0;
            first_ff <= 1'b0;
        end else begin
            unique case (seq_ff)
                SQ_IDLE: begin
                    if (phase_ff == PH_FOUR && (req_pend_ff || EXT_DATA_MOVE_REQ)) begin
                        seq_ff <= SQ_FETCH;
                    end
                end
                SQ_FETCH: begin
                    if (phase_ff == PH_FOUR) begin
                        seq_ff   <= SQ_ACCESS;
                        rem_ff   <= ACCESS_BASE_CYCLES + {1'b0, stretch_ff};
                        short_ff <= (stretch_ff == 3'h0);
                        first_ff <= 1'b1;
                    end
                end
                SQ_ACCESS: begin
                    if (phase_ff == PH_FOUR) begin
                        first_ff <= 1'b0;
                        if (access_end) begin
                            seq_ff <= SQ_IDLE;
                        end else if (!ext_ff) begin
                            rem_ff <= rem_ff - 4'h1;
                        end
                    end
                end
                default: seq_ff <= SQ_IDLE;
            endcase
        end
    end

    // Pending wait, taken at state four to hold the cycle count
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ext_ff <= 1'b0;
        end else if (wait_hit) begin
            ext_ff <= 1'b1;
        end else if (phase_ff == PH_FOUR) begin
            ext_ff <= 1'b0;
        end
    end

    // Strobe: short form states two and three, long form three to two
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            strobe_ff <= 1'b0;
        end else if (seq_ff == SQ_ACCESS && first_ff && !strobe_ff
                     && phase_ff == (short_ff ? PH_ONE : PH_TWO)) begin
            strobe_ff <= 1'b1;
        end else if (strobe_ff && rem_ff == 4'h1 && !first_ff && !short_ff
                     && phase_ff == PH_TWO) begin
            strobe_ff <= 1'b0;
        end else if (strobe_ff && short_ff && rem_ff == 4'h1 && phase_ff == PH_THREE
                     && !wait_hit) begin
            strobe_ff <= 1'b0;
        end
    end
    assign EXT_RD_N = !(strobe_ff && !write_ff);
    assign EXT_WR_N = !(strobe_ff && write_ff);

    // Address and write data latched at fetch end, held through the access
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            EXT_ADDR    <= 16'h0000;
            EXT_DATA_O  <= 8'h00;
            EXT_DATA_OE <= 1'b0;
            write_ff    <= 1'b0;
        end else if (seq_ff == SQ_FETCH && phase_ff == PH_FOUR) begin
            EXT_ADDR    <= EXT_DATA_MOVE_USE_PTR ? sel_pointer : {EXT_DATA_MOVE_PAGE_ADDR, EXT_DATA_MOVE_RI_ADDR};
            EXT_DATA_O  <= EXT_DATA_MOVE_WDATA;
            EXT_DATA_OE <= EXT_DATA_MOVE_WRITE;
            write_ff    <= EXT_DATA_MOVE_WRITE;
        end else if (access_end) begin
            EXT_DATA_OE <= 1'b0;
        end
    end

    // Read data caught at the strobe end, done one clock after the last state
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            EXT_DATA_MOVE_RDATA <= 8'h00;
            EXT_DATA_MOVE_DONE  <= 1'b0;
        end else begin
            EXT_DATA_MOVE_DONE <= access_end;
            if (strobe_ff && !write_ff) begin
                EXT_DATA_MOVE_RDATA <= EXT_DATA_I;
            end
        end
    end

    assign EXT_DATA_MOVE_BUSY = (seq_ff != SQ_IDLE);
    // Core state held only for stretch and wait cycles of the move; with stretch zero, only state four of each wait cycle
    assign CPU_HOLD  = (seq_ff == SQ_ACCESS) && ((rem_ff != 4'h1) || ext_ff);

    // Helper counters for checks
    logic [7:0] chk_strobe_len;
    logic [7:0] chk_total_len;
    logic       chk_waited;
    logic [2:0] chk_stretch;
    logic [7:0] chk_expect_strobe;
    logic [7:0] chk_expect_total;

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            chk_strobe_len <= 8'h00;
            chk_total_len  <= 8'h00;
            chk_waited     <= 1'b0;
            chk_stretch    <= 3'h0;
        end else begin
            chk_strobe_len <= strobe_ff ? chk_strobe_len + 8'h01 : 8'h00;
            chk_total_len  <= (seq_ff == SQ_IDLE) ? 8'h00 : chk_total_len + 8'h01;
            if (seq_ff == SQ_FETCH) begin
                chk_waited  <= 1'b0;
                chk_stretch <= stretch_ff;
            end else if (wait_hit) begin
                chk_waited <= 1'b1;
            end
        end
    end
    assign chk_expect_strobe = (chk_stretch == 3'h0) ? 8'h02 : {3'h0, chk_stretch, 2'h0};
    assign chk_expect_total  = {2'h0, 4'h2 + {1'b0, chk_stretch}, 2'h0} - 8'h01;

    sequence seq_fetch_quiet;
        (seq_ff == SQ_FETCH && !strobe_ff) [*4];
    endsequence

    sequence seq_access_open;
        (seq_ff == SQ_ACCESS);
    endsequence

    chk_fetch_first: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (seq_ff == SQ_IDLE && phase_ff == PH_FOUR && (req_pend_ff || EXT_DATA_MOVE_REQ))
        |=> seq_fetch_quiet ##1 seq_access_open)
        else $error("move did not start with a quiet fetch cycle");

    chk_phase_order: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (phase_ff == PH_FOUR) |=> (phase_ff == PH_ONE) ##1 (phase_ff == PH_TWO))
        else $error("machine states out of order");

    chk_strobe_width: assert property (@(posedge SYS_CLK) disable iff (RESET)
        ($fell(strobe_ff) && !chk_waited) |-> ($past(chk_strobe_len) + 8'h01 == chk_expect_strobe))
        else $error("strobe width wrong for stretch value");

    chk_move_length: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (access_end && !chk_waited) |-> (chk_total_len == chk_expect_total))
        else $error("move length wrong for stretch value");

    chk_wait_extends: assert property (@(posedge SYS_CLK) disable iff (RESET)
        wait_hit |=> strobe_ff [*4])
        else $error("wait did not extend the strobe");

    chk_addr_stable: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (strobe_ff && $past(strobe_ff)) |-> ($stable(EXT_ADDR) && $stable(EXT_DATA_O)))
        else $error("address or data moved under strobe");

    chk_pointer_pick: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (seq_ff == SQ_FETCH && phase_ff == PH_FOUR && EXT_DATA_MOVE_USE_PTR) |=> (EXT_ADDR == $past(sel_pointer)))
        else $error("address not from selected pointer");

    chk_hold_scope: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (seq_ff != SQ_ACCESS) |-> !CPU_HOLD)
        else $error("core held outside a move");

endmodule : edxs_top

`default_nettype wire

// ---- pkg/edxs_pkg.sv ----
// Purpose: Shared constants and types for the external data access stretch block
// Assumes: Byte-wide register port, four clocks per machine cycle
// Notes:   Offsets are byte addresses on the register port
`default_nettype none

package edxs_pkg;

    // Register offsets
    localparam logic [7:0] OFS_PRIMARY_LO   = 8'h82;
    localparam logic [7:0] OFS_PRIMARY_HI   = 8'h83;
    localparam logic [7:0] OFS_SECONDARY_LO = 8'h84;
    localparam logic [7:0] OFS_SECONDARY_HI = 8'h85;
    localparam logic [7:0] OFS_POINTER_SEL  = 8'h86;
    localparam logic [7:0] OFS_CLOCK_CTRL   = 8'h8e;
    localparam logic [7:0] OFS_MEMORY_MAP   = 8'h9c;
    localparam logic [7:0] OFS_TIMED_ACCESS = 8'hc7;

    // Field positions
    localparam int STRETCH_LSB      = 0;
    localparam int STRETCH_MSB      = 2;
    localparam int WAIT_ENABLE_BIT  = 7;
    localparam int POINTER_SEL_BIT  = 0;

    // Values after reset
    localparam logic [2:0] STRETCH_RESET     = 3'h1;
    localparam logic       WAIT_ENABLE_RESET = 1'b0;
    localparam logic       POINTER_SEL_RESET = 1'b0;
    localparam logic [7:0] POINTER_RESET     = 8'h00;

    // Unlock sequence for protected bits
    localparam logic [7:0] TA_KEY_FIRST  = 8'haa;
    localparam logic [7:0] TA_KEY_SECOND = 8'h55;

    // Cycle counts and aux pin idle level
    localparam int         CLOCKS_PER_MACHINE = 4;
    localparam int         TA_WINDOW_MACHINES = 3;
    localparam logic [3:0] TA_WINDOW_CLOCKS   = 4'(TA_WINDOW_MACHINES * CLOCKS_PER_MACHINE);
    localparam logic [3:0] ACCESS_BASE_CYCLES = 4'h1;
    localparam logic       AUX_IDLE_LEVEL     = 1'b1;

    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} edxs_phase_t;
    typedef enum logic [1:0] {SQ_IDLE, SQ_FETCH, SQ_ACCESS} edxs_seq_t;
    typedef enum logic [1:0] {TA_LOCKED, TA_ARMED, TA_OPEN} edxs_ta_t;

endpackage : edxs_pkg

`default_nettype wire

// ---- hw/edxs_pin_sync.sv ----
// Purpose: Brings an asynchronous pin level into the clock domain
// Assumes: Pin idles at the reset level
// Notes:   A change is accepted once the second and third stages agree
`timescale 1ns/100ps
`default_nettype none

module edxs_pin_sync (
    // Clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RESET,
    // Pin and result
    input  wire logic PIN_IN,
    output var  logic LEVEL
);
    import edxs_pkg::*;

    logic stage1_ff;
    logic stage2_ff;
    logic stage3_ff;

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            stage1_ff <= AUX_IDLE_LEVEL;
            stage2_ff <= AUX_IDLE_LEVEL;
            stage3_ff <= AUX_IDLE_LEVEL;
        end else begin
            stage1_ff <= PIN_IN;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            LEVEL <= AUX_IDLE_LEVEL;
        end else if (stage2_ff == stage3_ff) begin
            LEVEL <= stage3_ff;
        end
    end

endmodule : edxs_pin_sync

`default_nettype wire

// ---- verification/edxs_ext_mem.sv ----
// Purpose: External data memory model with a slow region that asks for waits
// Assumes: Wait line is open drain with a pull-up outside this model
// Notes:   Addresses with bit 15 set are slow; released data lines idle inverted
`timescale 1ns/100ps
`default_nettype none

module edxs_ext_mem (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    // External bus
    input  wire logic [15:0] EXT_ADDR,
    input  wire logic [7:0]  EXT_DATA_O,
    input  wire logic        EXT_RD_N,
    input  wire logic        EXT_WR_N,
    output var  logic [7:0]  EXT_DATA_I,
    // Wait request, low while busy
    input  wire logic [3:0]  WAIT_CLOCKS,
    output var  logic        WAIT_N
);
    logic [7:0] mem [0:255];
    logic [7:0] last_ff;
    logic [3:0] busy_ff;

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            busy_ff <= 4'h0;
            last_ff <= 8'h00;
        end else begin
            // Busy time restarts whenever no strobe is active
            if (EXT_RD_N && EXT_WR_N)
                busy_ff <= WAIT_CLOCKS;
            else if (busy_ff != 4'h0)
                busy_ff <= busy_ff - 4'h1;
            if (!EXT_WR_N)
                mem[EXT_ADDR[7:0]] <= EXT_DATA_O;
            if (!EXT_RD_N)
                last_ff <= mem[EXT_ADDR[7:0]];
        end
    end

    // Slow region holds wait low until its busy time has run out
    always_comb WAIT_N = !(EXT_ADDR[15] && busy_ff != 4'h0);
    always_comb EXT_DATA_I = EXT_RD_N ? ~last_ff : mem[EXT_ADDR[7:0]];
endmodule : edxs_ext_mem

`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the external data access stretch block
// Assumes: Partner memory on the external bus, pull-up on the aux pin
// Notes:   Moves are timed by counting busy and strobe clocks
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import edxs_pkg::*;
    logic        sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, ri = 8'h00, page = 8'h00;
    logic [7:0]  mwdata = 8'h00, reg_rdata, ext_data_move_rdata, ext_di, ext_do, r;
    logic        mreq = 1'b0, mwrite = 1'b0, muse = 1'b0, latch = 1'b0;
    logic        done, busy, hold, aux_level, aux_o, aux_oe, ext_oe, rd_n, wr_n, wait_n;
    logic [1:0]  mstate, prev;
    logic [15:0] ext_addr, seen;
    logic [3:0]  wait_clocks = 4'h0;
    wire  logic  aux_pin = aux_oe ? 1'b0 : wait_n;
    int          n_errors = 0, checks_done = 0, cycles = 0, clk_n, stb_n, c1, hold_n;

    always #50 sys_clk = ~sys_clk;

    edxs_top u_dut (.SYS_CLK(sys_clk), .RESET(reset), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .EXT_DATA_MOVE_REQ(mreq), .EXT_DATA_MOVE_WRITE(mwrite), .EXT_DATA_MOVE_USE_PTR(muse), .EXT_DATA_MOVE_RI_ADDR(ri),
        .EXT_DATA_MOVE_PAGE_ADDR(page), .EXT_DATA_MOVE_WDATA(mwdata), .EXT_DATA_MOVE_RDATA(ext_data_move_rdata),
        .EXT_DATA_MOVE_DONE(done), .EXT_DATA_MOVE_BUSY(busy), .CPU_HOLD(hold), .MACHINE_STATE(mstate),
        .AUX_PORT_LATCH(latch), .AUX_PORT_LEVEL(aux_level), .AUX0_I(aux_pin),
        .AUX0_O(aux_o), .AUX0_OE(aux_oe), .EXT_ADDR(ext_addr), .EXT_DATA_I(ext_di),
        .EXT_DATA_O(ext_do), .EXT_DATA_OE(ext_oe), .EXT_RD_N(rd_n), .EXT_WR_N(wr_n));

    edxs_ext_mem u_mem (.SYS_CLK(sys_clk), .RESET(reset), .EXT_ADDR(ext_addr),
        .EXT_DATA_O(ext_do), .EXT_RD_N(rd_n), .EXT_WR_N(wr_n), .EXT_DATA_I(ext_di),
        .WAIT_CLOCKS(wait_clocks), .WAIT_N(wait_n));

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        r = reg_rdata;
    endtask : rd

    task automatic move(input logic w, input logic p, input logic [15:0] a, input logic [7:0] d);
        int guard;
        clk_n = 0;
        stb_n = 0;
        hold_n = 0;
        guard = 0;
        @(posedge sys_clk);
        mreq <= 1'b1;
        mwrite <= w;
        muse <= p;
        {page, ri} <= a;
        mwdata <= d;
        // Move request is a one-clock pulse
        @(posedge sys_clk);
        mreq <= 1'b0;
        do begin
            @(negedge sys_clk);
            guard++;
            if (busy === 1'b1)
                clk_n++;
            if (hold === 1'b1)
                hold_n++;
            if ((rd_n & wr_n) === 1'b0) begin
                if (stb_n == 0)
                    seen = ext_addr;
                stb_n++;
                check("address hold", seen, ext_addr);
                check("data drive", {15'h0, w}, {15'h0, ext_oe});
                if (w)
                    check("write data hold", {8'h00, d}, {8'h00, ext_do});
            end
        end while (done !== 1'b1 && guard < 300);
        check("move done", 16'h1, {15'h0, done});
    endtask : move

    task automatic tally_and_finish;
        $display("checks done %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(OFS_CLOCK_CTRL);
        check("stretch after reset", 16'h1, {13'h0, r[2:0]});
        rd(OFS_MEMORY_MAP);
        check("wait enable after reset", 16'h0, {15'h0, r[7]});
        rd(OFS_POINTER_SEL);
        check("pointer select after reset", 16'h0, {8'h00, r});
        check("aux pin driven by latch", 16'h1, {15'h0, aux_oe});
        check("aux drives low", 16'h0, {15'h0, aux_o});
        check("aux level after reset", 16'h0, {15'h0, aux_level});
        @(posedge sys_clk);
        latch <= 1'b1;
        @(negedge sys_clk);
        check("aux pin released by latch", 16'h0, {15'h0, aux_oe});
        @(posedge sys_clk);
        latch <= 1'b0;
        @(negedge sys_clk);
        prev = mstate;
        repeat (8) begin
            @(negedge sys_clk);
            check("machine state order", {14'h0, prev + 2'h1}, {14'h0, mstate});
            prev = mstate;
        end
        move(1'b1, 1'b0, 16'h0105, 8'h3c);
        check("default move clocks", 16'd12, 16'(clk_n));
        check("default strobe clocks", 16'd4, 16'(stb_n));
        $display("test reset done");

        for (int s = 0; s < 8; s++) begin
            wr(OFS_CLOCK_CTRL, 8'(s));
            wr(8'h10, 8'h07);
            rd(OFS_CLOCK_CTRL);
            check("stretch field", 16'(s), {13'h0, r[2:0]});
            move(1'b1, 1'b0, 16'h0100 + 16'(s), 8'ha0 + 8'(s));
            check("write move clocks", 16'(4 * (2 + s)), 16'(clk_n));
            check("write strobe", 16'(s == 0 ? 2 : 4 * s), 16'(stb_n));
            check("write hold clocks", 16'(4 * s), 16'(hold_n));
            move(1'b0, 1'b0, 16'h0100 + 16'(s), 8'h00);
            check("read move clocks", 16'(4 * (2 + s)), 16'(clk_n));
            check("read strobe", 16'(s == 0 ? 2 : 4 * s), 16'(stb_n));
            check("read data", 16'h00a0 + 16'(s), {8'h00, ext_data_move_rdata});
            check("no hold when idle", 16'h0, {15'h0, hold});
        end
        $display("test stretch sweep done");

        wr(OFS_PRIMARY_LO, 8'h34);
        wr(OFS_PRIMARY_HI, 8'h12);
        wr(OFS_SECONDARY_LO, 8'h78);
        wr(OFS_SECONDARY_HI, 8'h56);
        wr(OFS_POINTER_SEL, 8'hff);
        rd(OFS_POINTER_SEL);
        check("pointer select read", 16'h01, {8'h00, r});
        move(1'b0, 1'b1, 16'h0000, 8'h00);
        check("secondary address", 16'h5678, seen);
        wr(OFS_POINTER_SEL, 8'h00);
        move(1'b1, 1'b1, 16'h0000, 8'h5a);
        check("primary address", 16'h1234, seen);
        $display("test pointers done");

        wr(OFS_MEMORY_MAP, 8'h80);
        rd(OFS_MEMORY_MAP);
        check("locked wait enable", 16'h0, {15'h0, r[7]});
        wr(OFS_TIMED_ACCESS, TA_KEY_FIRST);
        wr(OFS_TIMED_ACCESS, TA_KEY_SECOND);
        wr(OFS_MEMORY_MAP, 8'h80);
        rd(OFS_MEMORY_MAP);
        check("unlocked wait enable", 16'h1, {15'h0, r[7]});
        check("aux pin released", 16'h0, {15'h0, aux_oe});
        wr(OFS_CLOCK_CTRL, 8'h00);
        repeat (2) @(negedge sys_clk);
        check("aux level follows pin", 16'h1, {15'h0, aux_level});
        move(1'b0, 1'b0, 16'h0101, 8'h00);
        check("fast move with wait on", 16'd8, 16'(clk_n));
        wr(OFS_CLOCK_CTRL, 8'h02);
        move(1'b0, 1'b0, 16'h0101, 8'h00);
        check("stretch still minimum", 16'd16, 16'(clk_n));
        wait_clocks <= 4'h4;
        move(1'b0, 1'b0, 16'h8000, 8'h00);
        c1 = clk_n;
        check("wait lengthens move", 16'h1, {15'h0, c1 > 16});
        check("wait adds whole cycles", 16'h0, 16'(c1 % 4));
        wait_clocks <= 4'hc;
        move(1'b0, 1'b0, 16'h8000, 8'h00);
        check("longer wait longer move", 16'h1, {15'h0, clk_n > c1});
        check("read data after waits", 16'h00a0, {8'h00, ext_data_move_rdata});
        wr(OFS_CLOCK_CTRL, 8'h00);
        move(1'b0, 1'b0, 16'h8000, 8'h00);
        check("fast wait whole cycles", 16'h0, 16'(clk_n % 4));
        check("fast move held by wait", 16'h1, {15'h0, clk_n > 8});
        check("fast wait read data", 16'h00a0, {8'h00, ext_data_move_rdata});
        $display("test wait control done");
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
